// ==== rtl/rtccal_consts.svh ====
`ifndef RTCCAL_CONSTS_SVH
`define RTCCAL_CONSTS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define RTCCAL_IDX_STATUS   6'h01
`define RTCCAL_IDX_SEC      6'h09
`define RTCCAL_IDX_MIN      6'h0a
`define RTCCAL_IDX_HRS      6'h0b
`define RTCCAL_IDX_WDAY     6'h0c
`define RTCCAL_IDX_DATE     6'h0d
`define RTCCAL_IDX_MON      6'h0e
`define RTCCAL_IDX_YEAR     6'h0f
`define RTCCAL_IDX_A1_SEC   6'h10
`define RTCCAL_IDX_A1_MIN   6'h11
`define RTCCAL_IDX_A1_HRS   6'h12
`define RTCCAL_IDX_A1_DAY   6'h13
`define RTCCAL_IDX_A1_MON   6'h14
`define RTCCAL_IDX_A1_YEAR  6'h15

// Writable bits of each register; all other bits read as zero.
`define RTCCAL_WM_STATUS    8'h01
`define RTCCAL_WM_SEC       8'h7f
`define RTCCAL_WM_MIN       8'h7f
`define RTCCAL_WM_HRS       8'h7f
`define RTCCAL_WM_WDAY      8'h07
`define RTCCAL_WM_DATE      8'h3f
`define RTCCAL_WM_MON       8'h9f
`define RTCCAL_WM_YEAR      8'hff
`define RTCCAL_WM_A1_SEC    8'hff
`define RTCCAL_WM_A1_MIN    8'hff
`define RTCCAL_WM_A1_HRS    8'hbf
`define RTCCAL_WM_A1_DAY    8'hff
`define RTCCAL_WM_A1_MON    8'hdf
`define RTCCAL_WM_A1_YEAR   8'hff

// Reset values.
`define RTCCAL_RST_ZERO     8'h00
`define RTCCAL_RST_WDAY     8'h01
`define RTCCAL_RST_DATE     8'h01
`define RTCCAL_RST_MON      8'h01

// Field positions.
`define RTCCAL_HR_MODE_BIT  6
`define RTCCAL_HR_PM_BIT    5
`define RTCCAL_CENTURY_BIT  7
`define RTCCAL_MASK_BIT     7
`define RTCCAL_WDAY_SEL_BIT 6
`define RTCCAL_YR_MASK_BIT  6
`define RTCCAL_STAT_BIT     0

// Counting limits, in BCD.
`define RTCCAL_BCD_NINE     4'h9
`define RTCCAL_BCD_ZERO     8'h00
`define RTCCAL_SEC_LAST     8'h59
`define RTCCAL_H24_LAST     8'h23
`define RTCCAL_H12_LAST     8'h12
`define RTCCAL_H12_FIRST    8'h01
`define RTCCAL_H12_PM_FLIP  8'h11
`define RTCCAL_WDAY_LAST    3'h7
`define RTCCAL_WDAY_FIRST   3'h1
`define RTCCAL_MON_LAST     8'h12
`define RTCCAL_MON_FIRST    8'h01
`define RTCCAL_DATE_FIRST   8'h01
`define RTCCAL_YEAR_LAST    8'h99
`define RTCCAL_DAYS_28      8'h28
`define RTCCAL_DAYS_29      8'h29
`define RTCCAL_DAYS_30      8'h30
`define RTCCAL_DAYS_31      8'h31
`define RTCCAL_MON_FEB      5'h02
`define RTCCAL_MON_APR      5'h04
`define RTCCAL_MON_JUN      5'h06
`define RTCCAL_MON_SEP      5'h09
`define RTCCAL_MON_NOV      5'h11

// Bus encodings.
`define RTCCAL_SIZE_WORD    3'h2
`define RTCCAL_HRESP_OKAY   1'b0

`endif

// ==== rtl/rtccal_pkg.sv ====
package rtccal_pkg;

	// Hour counting format held in the hours register.
	typedef enum logic {
		RTCCAL_HOUR_24 = 1'b0,
		RTCCAL_HOUR_12 = 1'b1
	} rtccal_hour_mode_t;

	typedef logic [7:0] rtccal_byte_t;

endpackage

// ==== rtl/rtccal_bcd_step.sv ====
`timescale 1ns/1ps
`include "rtccal_consts.svh"

// One BCD pair counting step; a value at or above the last code wraps, so
// a bad value written by software cannot run away past the limit.
module rtccal_bcd_step (
	// Present value and range.
	input  wire logic [7:0] cur,
	input  wire logic [7:0] last,
	input  wire logic [7:0] first,
	// Next value and wrap flag.
	output logic      [7:0] nxt,
	output logic            wrap
);

	// Increment with decimal carry from units into tens.
	always_comb begin
		wrap = (cur >= last);
		if (wrap) begin
			nxt = first;
		end else if (cur[3:0] >= `RTCCAL_BCD_NINE) begin
			nxt = {cur[7:4] + 4'h1, 4'h0};
		end else begin
			nxt = {cur[7:4], cur[3:0] + 4'h1};
		end
	end

endmodule

// ==== rtl/rtccal_top.sv ====
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rtccal_consts.svh"

module rtccal_top (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Timekeeping.
	input  wire logic        second_tick,
	output logic             alarm_one_pulse
);

	// Register state.
	rtccal_pkg::rtccal_byte_t sec_reg, min_reg, hours_reg, wday_reg, date_reg;
	rtccal_pkg::rtccal_byte_t month_reg, year_reg;
	rtccal_pkg::rtccal_byte_t a1_sec_reg, a1_min_reg, a1_hrs_reg, a1_day_reg;
	rtccal_pkg::rtccal_byte_t a1_mon_reg, a1_year_reg;
	logic                     alarm_flag_reg;
	logic                     tick_d_reg;
	logic                     alarm_pulse_reg;
	logic [31:0]              hrdata_reg;
	logic                     wr_pend_reg;
	logic [5:0]               wr_idx_reg;
	logic                     hreadyout_reg;

	// Bus decode.
	logic                     accept;
	logic [5:0]               ad_idx;
	logic                     rd_hit_wr;
	rtccal_pkg::rtccal_byte_t wdata_m;
	rtccal_pkg::rtccal_byte_t rd_byte;

	// Calendar stepping.
	rtccal_pkg::rtccal_hour_mode_t hour_mode;
	rtccal_pkg::rtccal_byte_t sec_nxt, min_nxt, hr_nxt, date_nxt, mon_nxt, year_nxt;
	rtccal_pkg::rtccal_byte_t hr_cur, hr_last, hr_first, hours_next, dim;
	logic                     sec_wrap, min_wrap, hr_wrap, date_wrap, mon_wrap, year_wrap;
	logic                     min_carry, hr_carry, day_carry, mon_carry, yr_carry, cen_carry;
	logic                     leap;

	// Alarm compare.
	logic                     sec_eq, min_eq, hr_eq, day_eq, mon_eq, yr_eq, all_eq;

	// Writable-bit mask per register; zero marks an unmapped index.
	function automatic rtccal_pkg::rtccal_byte_t wmask(input logic [5:0] idx);
		unique case (idx)
			`RTCCAL_IDX_STATUS:  wmask = `RTCCAL_WM_STATUS;
			`RTCCAL_IDX_SEC:     wmask = `RTCCAL_WM_SEC;
			`RTCCAL_IDX_MIN:     wmask = `RTCCAL_WM_MIN;
			`RTCCAL_IDX_HRS:     wmask = `RTCCAL_WM_HRS;
			`RTCCAL_IDX_WDAY:    wmask = `RTCCAL_WM_WDAY;
			`RTCCAL_IDX_DATE:    wmask = `RTCCAL_WM_DATE;
			`RTCCAL_IDX_MON:     wmask = `RTCCAL_WM_MON;
			`RTCCAL_IDX_YEAR:    wmask = `RTCCAL_WM_YEAR;
			`RTCCAL_IDX_A1_SEC:  wmask = `RTCCAL_WM_A1_SEC;
			`RTCCAL_IDX_A1_MIN:  wmask = `RTCCAL_WM_A1_MIN;
			`RTCCAL_IDX_A1_HRS:  wmask = `RTCCAL_WM_A1_HRS;
			`RTCCAL_IDX_A1_DAY:  wmask = `RTCCAL_WM_A1_DAY;
			`RTCCAL_IDX_A1_MON:  wmask = `RTCCAL_WM_A1_MON;
			`RTCCAL_IDX_A1_YEAR: wmask = `RTCCAL_WM_A1_YEAR;
			default:             wmask = `RTCCAL_RST_ZERO;
		endcase
	endfunction

	// Address phase decode; upper address bits must be zero to hit.
	assign accept  = hsel && htrans[1] && hready;
	assign ad_idx  = (haddr[31:8] == 24'h000000) ? haddr[7:2] : 6'h00;
	assign wdata_m = hwdata[7:0] & wmask(wr_idx_reg);

	// A read right behind a write to the same word sees the new value, or for the status word the bits written.
	assign rd_hit_wr = wr_pend_reg && (wr_idx_reg == ad_idx);

	// Read multiplexer over the present register contents.
	always_comb begin
		unique case (ad_idx)
			`RTCCAL_IDX_STATUS:  rd_byte = {7'h00, alarm_flag_reg};
			`RTCCAL_IDX_SEC:     rd_byte = sec_reg;
			`RTCCAL_IDX_MIN:     rd_byte = min_reg;
			`RTCCAL_IDX_HRS:     rd_byte = hours_reg;
			`RTCCAL_IDX_WDAY:    rd_byte = wday_reg;
			`RTCCAL_IDX_DATE:    rd_byte = date_reg;
			`RTCCAL_IDX_MON:     rd_byte = month_reg;
			`RTCCAL_IDX_YEAR:    rd_byte = year_reg;
			`RTCCAL_IDX_A1_SEC:  rd_byte = a1_sec_reg;
			`RTCCAL_IDX_A1_MIN:  rd_byte = a1_min_reg;
			`RTCCAL_IDX_A1_HRS:  rd_byte = a1_hrs_reg;
			`RTCCAL_IDX_A1_DAY:  rd_byte = a1_day_reg;
			`RTCCAL_IDX_A1_MON:  rd_byte = a1_mon_reg;
			`RTCCAL_IDX_A1_YEAR: rd_byte = a1_year_reg;
			default:             rd_byte = `RTCCAL_RST_ZERO;
		endcase
	end

	// Address phase capture; only whole-word writes are honoured.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg   <= 1'b0;
			wr_idx_reg    <= 6'h00;
			hreadyout_reg <= 1'b0;                                 // Not ready while in reset.
		end else begin
			wr_pend_reg   <= accept && hwrite && (hsize == `RTCCAL_SIZE_WORD);
			wr_idx_reg    <= ad_idx;
			hreadyout_reg <= 1'b1;
		end
	end

	// Read data is registered so the slave answers with no wait state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (accept && !hwrite) begin
			hrdata_reg <= {24'h000000, rd_hit_wr ? wdata_m : rd_byte};
		end else begin
			hrdata_reg <= 32'h00000000;
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp     = `RTCCAL_HRESP_OKAY;

	// Leap years: year divisible by four, except the century year 2100.
	always_comb begin
		leap = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6)
		                   : (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 ||
		                      year_reg[3:0] == 4'h8);
		if (year_reg == `RTCCAL_BCD_ZERO && month_reg[`RTCCAL_CENTURY_BIT]) begin
			leap = 1'b0;
		end
		unique case (month_reg[4:0])
			`RTCCAL_MON_FEB: dim = leap ? `RTCCAL_DAYS_29 : `RTCCAL_DAYS_28;
			`RTCCAL_MON_APR, `RTCCAL_MON_JUN,
			`RTCCAL_MON_SEP, `RTCCAL_MON_NOV: dim = `RTCCAL_DAYS_30;
			default: dim = `RTCCAL_DAYS_31;
		endcase
	end

	// Hour range follows the selected format.
	assign hour_mode = rtccal_pkg::rtccal_hour_mode_t'(hours_reg[`RTCCAL_HR_MODE_BIT]);
	always_comb begin
		if (hour_mode == rtccal_pkg::RTCCAL_HOUR_12) begin
			hr_cur   = {3'h0, hours_reg[4:0]};
			hr_last  = `RTCCAL_H12_LAST;
			hr_first = `RTCCAL_H12_FIRST;
		end else begin
			hr_cur   = {2'h0, hours_reg[5:0]};
			hr_last  = `RTCCAL_H24_LAST;
			hr_first = `RTCCAL_BCD_ZERO;
		end
	end

	rtccal_bcd_step u_sec  (.cur(sec_reg),   .last(`RTCCAL_SEC_LAST), .first(`RTCCAL_BCD_ZERO),
	                        .nxt(sec_nxt),   .wrap(sec_wrap));
	rtccal_bcd_step u_min  (.cur(min_reg),   .last(`RTCCAL_SEC_LAST), .first(`RTCCAL_BCD_ZERO),
	                        .nxt(min_nxt),   .wrap(min_wrap));
	rtccal_bcd_step u_hr   (.cur(hr_cur),    .last(hr_last),          .first(hr_first),
	                        .nxt(hr_nxt),    .wrap(hr_wrap));
	rtccal_bcd_step u_date (.cur(date_reg),  .last(dim),              .first(`RTCCAL_DATE_FIRST),
	                        .nxt(date_nxt),  .wrap(date_wrap));
	rtccal_bcd_step u_mon  (.cur({3'h0, month_reg[4:0]}), .last(`RTCCAL_MON_LAST),
	                        .first(`RTCCAL_MON_FIRST), .nxt(mon_nxt), .wrap(mon_wrap));
	rtccal_bcd_step u_year (.cur(year_reg),  .last(`RTCCAL_YEAR_LAST), .first(`RTCCAL_BCD_ZERO),
	                        .nxt(year_nxt),  .wrap(year_wrap));

	// Carry chain; in 12h mode the day turns at 11 PM to 12 AM, and the
	// flag flips on the 11 to 12 step.
	assign min_carry = second_tick && sec_wrap;
	assign hr_carry  = min_carry && min_wrap;
	assign day_carry = hr_carry && ((hour_mode == rtccal_pkg::RTCCAL_HOUR_12)
	                   ? (hours_reg[`RTCCAL_HR_PM_BIT] && hr_cur == `RTCCAL_H12_PM_FLIP)
	                   : hr_wrap);
	assign mon_carry = day_carry && date_wrap;
	assign yr_carry  = mon_carry && mon_wrap;
	assign cen_carry = yr_carry && year_wrap;
	assign hours_next = (hour_mode == rtccal_pkg::RTCCAL_HOUR_12)
	                  ? {2'b01, hours_reg[`RTCCAL_HR_PM_BIT] ^ (hr_cur == `RTCCAL_H12_PM_FLIP),
	                     hr_nxt[4:0]}
	                  : {2'b00, hr_nxt[5:0]};

	// Time and date registers; a software write beats a tick that lands
	// in the same cycle, since software means to set the new value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_reg   <= `RTCCAL_RST_ZERO;
			min_reg   <= `RTCCAL_RST_ZERO;
			hours_reg <= `RTCCAL_RST_ZERO;
			wday_reg  <= `RTCCAL_RST_WDAY;
			date_reg  <= `RTCCAL_RST_DATE;
			month_reg <= `RTCCAL_RST_MON;
			year_reg  <= `RTCCAL_RST_ZERO;
		end else begin
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_SEC) begin
				sec_reg <= wdata_m;
			end else if (second_tick) begin
				sec_reg <= sec_nxt;
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_MIN) begin
				min_reg <= wdata_m;
			end else if (min_carry) begin
				min_reg <= min_nxt;
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_HRS) begin
				hours_reg <= wdata_m;
			end else if (hr_carry) begin
				hours_reg <= hours_next;
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_WDAY) begin
				wday_reg <= wdata_m;
			end else if (day_carry) begin
				wday_reg[2:0] <= (wday_reg[2:0] >= `RTCCAL_WDAY_LAST) ? `RTCCAL_WDAY_FIRST
				                 : wday_reg[2:0] + 3'h1;
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_DATE) begin
				date_reg <= wdata_m;
			end else if (day_carry) begin
				date_reg <= date_nxt;
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_MON) begin
				month_reg <= wdata_m;
			end else if (mon_carry) begin
				month_reg <= {month_reg[`RTCCAL_CENTURY_BIT] ^ cen_carry, 2'b00,
				              mon_nxt[4:0]};
			end
			if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_YEAR) begin
				year_reg <= wdata_m;
			end else if (yr_carry) begin
				year_reg <= year_nxt;
			end
		end
	end

	// First alarm compare registers, written by software only.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a1_sec_reg  <= `RTCCAL_RST_ZERO;
			a1_min_reg  <= `RTCCAL_RST_ZERO;
			a1_hrs_reg  <= `RTCCAL_RST_ZERO;
			a1_day_reg  <= `RTCCAL_RST_ZERO;
			a1_mon_reg  <= `RTCCAL_RST_ZERO;
			a1_year_reg <= `RTCCAL_RST_ZERO;
		end else if (wr_pend_reg) begin
			unique case (wr_idx_reg)
				`RTCCAL_IDX_A1_SEC:  a1_sec_reg  <= wdata_m;
				`RTCCAL_IDX_A1_MIN:  a1_min_reg  <= wdata_m;
				`RTCCAL_IDX_A1_HRS:  a1_hrs_reg  <= wdata_m;
				`RTCCAL_IDX_A1_DAY:  a1_day_reg  <= wdata_m;
				`RTCCAL_IDX_A1_MON:  a1_mon_reg  <= wdata_m;
				`RTCCAL_IDX_A1_YEAR: a1_year_reg <= wdata_m;
				default: ;
			endcase
		end
	end

	// Per-field compare; a set mask bit takes the field out.
	assign sec_eq = a1_sec_reg[`RTCCAL_MASK_BIT] || (a1_sec_reg[6:0] == sec_reg[6:0]);
	assign min_eq = a1_min_reg[`RTCCAL_MASK_BIT] || (a1_min_reg[6:0] == min_reg[6:0]);
	assign hr_eq  = a1_hrs_reg[`RTCCAL_MASK_BIT] || (a1_hrs_reg[5:0] == hours_reg[5:0]);
	assign day_eq = a1_day_reg[`RTCCAL_MASK_BIT] ||
	                (a1_day_reg[`RTCCAL_WDAY_SEL_BIT] ? (a1_day_reg[2:0] == wday_reg[2:0])
	                                                  : (a1_day_reg[5:0] == date_reg[5:0]));
	assign mon_eq = a1_mon_reg[`RTCCAL_MASK_BIT] || (a1_mon_reg[4:0] == month_reg[4:0]);
	assign yr_eq  = a1_mon_reg[`RTCCAL_YR_MASK_BIT] || (a1_year_reg == year_reg);
	assign all_eq = sec_eq && min_eq && hr_eq && day_eq && mon_eq && yr_eq;

	// The compare is judged one cycle after the tick, on the new time, so
	// a fully masked alarm fires once per second and not continuously.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_d_reg      <= 1'b0;
			alarm_pulse_reg <= 1'b0;
		end else begin
			tick_d_reg      <= second_tick;
			alarm_pulse_reg <= tick_d_reg && all_eq;
		end
	end

	assign alarm_one_pulse = alarm_pulse_reg;

	// Sticky alarm flag, write one to clear; a new match wins the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_flag_reg <= 1'b0;
		end else if (alarm_pulse_reg) begin
			alarm_flag_reg <= 1'b1;
		end else if (wr_pend_reg && wr_idx_reg == `RTCCAL_IDX_STATUS &&
		             wdata_m[`RTCCAL_STAT_BIT]) begin
			alarm_flag_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sec_step_a: assert property (second_tick && !wr_pend_reg && sec_reg == 8'h09
		|=> sec_reg == 8'h10) else $error("seconds did not carry into tens");
	min_roll_a: assert property (hr_carry && !wr_pend_reg && min_reg == 8'h59
		|=> min_reg == 8'h00) else $error("minutes did not roll over");
	h24_wrap_a: assert property (hr_carry && !wr_pend_reg && hours_reg == 8'h23
		|=> hours_reg == 8'h00 && date_reg != $past(date_reg)) else $error("24h wrap wrong");
	h12_wrap_a: assert property (hr_carry && !wr_pend_reg && hours_reg[6:0] == 7'h72
		|=> hours_reg[6:0] == 7'h61) else $error("12h hour 12 PM did not go to 1 PM");
	pm_flip_a: assert property (hr_carry && !wr_pend_reg && hours_reg[6:0] == 7'h51
		|=> hours_reg[6:0] == 7'h72 && !$past(day_carry)) else $error("11 AM to 12 PM wrong");
	hour_tens_a: assert property (hr_carry && !wr_pend_reg && hours_reg == 8'h19
		|=> hours_reg == 8'h20) else $error("24h hour tens carry wrong");
	date_wrap_a: assert property (day_carry && !wr_pend_reg && date_reg == dim
		|=> date_reg == 8'h01 && month_reg[4:0] != $past(month_reg[4:0]))
		else $error("month end did not wrap");
	feb_leap_a: assert property (day_carry && !wr_pend_reg && month_reg == 8'h02
		&& year_reg == 8'h24 && date_reg == 8'h28 |=> date_reg == 8'h29)
		else $error("leap day skipped");
	year_cen_a: assert property (yr_carry && !wr_pend_reg && year_reg == 8'h99
		|=> year_reg == 8'h00 && month_reg[7] != $past(month_reg[7]) && month_reg[4:0] == 5'h01)
		else $error("century did not turn");
	year_tens_a: assert property (yr_carry && !wr_pend_reg && year_reg == 8'h19
		|=> year_reg == 8'h20) else $error("year tens carry wrong");
	wday_wrap_a: assert property (day_carry && !wr_pend_reg && wday_reg == 8'h07
		|=> wday_reg == 8'h01) else $error("weekday did not wrap");
	alarm_fire_a: assert property (tick_d_reg && all_eq
		|=> alarm_one_pulse ##1 alarm_flag_reg) else $error("alarm match missed");
	alarm_quiet_a: assert property (!(tick_d_reg && all_eq)
		|=> !alarm_one_pulse) else $error("alarm fired without match");
	sec_mask_a: assert property (tick_d_reg && !a1_sec_reg[7]
		&& a1_sec_reg[6:0] != sec_reg[6:0] |=> !alarm_one_pulse)
		else $error("unmasked seconds mismatch fired");
	wday_sel_a: assert property (tick_d_reg && a1_day_reg[7:6] == 2'b01
		&& a1_day_reg[2:0] != wday_reg[2:0] |=> !alarm_one_pulse)
		else $error("weekday mismatch fired");

endmodule

// ==== verification/rtccal_host.sv ====
`timescale 1ns/1ps

// Host software stand-in: single word transfers on the register bus, one at a time.
module rtccal_host (
	// Clock and slave answer.
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Request lines.
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	// The bus idles with no transfer pending.
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// Address phase held until ready, then data phase held until ready again.
	// On reads the write data lines toggle, so a slave cannot lean on stale data.
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? {24'h0, d} : ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("Error %s expected %h seen %h", n, e, a); end end

module tb;
	// Clock, reset and bus wires.
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        second_tick = 1'b0;
	logic        hsel, hwrite, hreadyout, hresp, alarm_one_pulse;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	int          failures = 0;
	int          checks = 0;
	int          cycles = 0;
	int          pulses;
	// Register index, reset value and writable bits.
	logic [5:0]  ridx [9] = '{6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13};
	logic [7:0]  rrst [9] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  rmsk [9] = '{8'h7f, 8'h07, 8'h3f, 8'h9f, 8'hff, 8'hff, 8'hff, 8'hbf, 8'hff};
	// Time before and after one tick, seconds through year.
	logic [7:0]  tin [6][7] = '{'{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
		'{8'h59, 8'h59, 8'h71, 8'h03, 8'h28, 8'h02, 8'h23},
		'{8'h59, 8'h59, 8'h51, 8'h05, 8'h15, 8'h06, 8'h24},
		'{8'h59, 8'h59, 8'h72, 8'h01, 8'h30, 8'h04, 8'h25},
		'{8'h59, 8'h59, 8'h19, 8'h05, 8'h15, 8'h06, 8'h24},
		'{8'h59, 8'h59, 8'h23, 8'h01, 8'h28, 8'h02, 8'h24}};
	logic [7:0]  tout [6][7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00},
		'{8'h00, 8'h00, 8'h52, 8'h04, 8'h01, 8'h03, 8'h23},
		'{8'h00, 8'h00, 8'h72, 8'h05, 8'h15, 8'h06, 8'h24},
		'{8'h00, 8'h00, 8'h61, 8'h01, 8'h30, 8'h04, 8'h25},
		'{8'h00, 8'h00, 8'h20, 8'h05, 8'h15, 8'h06, 8'h24},
		'{8'h00, 8'h00, 8'h00, 8'h02, 8'h29, 8'h02, 8'h24}};
	// Alarm day field, alarm seconds, pulses expected; time is 00:00:04, weekday 2, date 29.
	logic [7:0]  aday [5] = '{8'h42, 8'h43, 8'hc3, 8'hc3, 8'h29};
	logic [7:0]  asec [5] = '{8'h05, 8'h05, 8'h05, 8'h85, 8'h05};
	int          apul [5] = '{1, 0, 1, 1, 1};

	rtccal_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.second_tick(second_tick), .alarm_one_pulse(alarm_one_pulse));
	rtccal_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// 250 MHz clock.
	always #2 hclk = ~hclk;

	// A hang ends the run well past the roughly 500 cycles the tests need.
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end

	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		host.xfer(1'b1, i, d, q);
	endtask

	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		host.xfer(1'b0, i, 8'h00, q);
		`CHK($sformatf("register %h", i), {24'h0, e}, q)
	endtask

	// One second pulse, then the alarm pulses are counted over the following cycles.
	task automatic tick(input int exp_pulses);
		@(posedge hclk);
		second_tick <= 1'b1;
		@(posedge hclk);
		second_tick <= 1'b0;
		pulses = 0;
		repeat (5) begin
			@(posedge hclk);
			pulses += (alarm_one_pulse === 1'b1);
		end
		`CHK("alarm pulses", exp_pulses, pulses)
	endtask

	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Reset, register map, calendar carries, then alarm matching.
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 9; k++) rd(ridx[k], rrst[k]);
		for (int k = 0; k < 9; k++) begin
			wr(ridx[k], 8'hff);
			rd(ridx[k], rmsk[k]);
		end
		wr(6'h3e, 8'h5a);
		rd(6'h3e, 8'h00);
		for (int r = 0; r < 6; r++) begin
			for (int k = 0; k < 7; k++) wr(6'h09 + 6'(k), tin[r][k]);
			tick(0);
			for (int k = 0; k < 7; k++) rd(6'h09 + 6'(k), tout[r][k]);
		end
		wr(6'h14, 8'hc0);
		wr(6'h11, 8'h80);
		wr(6'h12, 8'h80);
		for (int r = 0; r < 5; r++) begin
			wr(6'h13, aday[r]);
			wr(6'h10, asec[r]);
			wr(6'h09, 8'h04);
			tick(apul[r]);
		end
		rd(6'h01, 8'h01);
		wr(6'h01, 8'h01);
		rd(6'h01, 8'h00);
		`CHK("response", 1'b0, hresp)
		end_sim();
	end
endmodule
